// *** rtl/asc_pkg.sv ***
/*
 * Constants for the asynchronous serial controller: register indices,
 * field positions, reset values and frame timing.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package asc_pkg;
    // register index; byte address is four times the index
    localparam logic [6:0] IDX_STATUS = 7'h50;
    localparam logic [6:0] IDX_DATA   = 7'h51;
    localparam logic [6:0] IDX_BAUD   = 7'h52;
    localparam logic [6:0] IDX_CTRL1  = 7'h53;
    localparam logic [6:0] IDX_CTRL2  = 7'h54;
    localparam int         ADDR_W     = 9;

    localparam int C1_TX9   = 6;
    localparam int C1_LPOFF = 5;
    localparam int C1_NINE  = 4;
    localparam int C1_WAKE  = 3;
    localparam int C1_PAR   = 2;
    localparam int C1_ODD   = 1;
    localparam int C1_PIE   = 0;

    localparam int C2_TIE   = 7;
    localparam int C2_DONE_IRQ_EN  = 6;
    localparam int C2_RIE   = 5;
    localparam int C2_QUIET_IRQ_EN  = 4;
    localparam int C2_TE    = 3;
    localparam int C2_RE    = 2;
    localparam int C2_MUTE  = 1;
    localparam int C2_BRK   = 0;

    localparam int BR_PRE_LSB = 6;
    localparam int BR_TX_LSB  = 3;
    localparam int BR_RX_LSB  = 0;

    localparam logic [6:0] CTRL1_RST = 7'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] BAUD_RST  = 8'h00;

    // prescaler terminal counts: factor minus one
    localparam logic [3:0] PRE_LAST0 = 4'h0;
    localparam logic [3:0] PRE_LAST1 = 4'h2;
    localparam logic [3:0] PRE_LAST2 = 4'h3;
    localparam logic [3:0] PRE_LAST3 = 4'hC;

    // sixteen rate ticks per bit
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_MID  = 4'h7;
    localparam logic [3:0] FRAME8    = 4'hA;
    localparam logic [3:0] FRAME9    = 4'hB;
endpackage

// *** rtl/asc_rate_gen.sv ***
/*
 * Rate generator: first prescaler followed by separate power-of-two
 * transmit and receive dividers, giving one-cycle rate ticks.
 * Assumes run is a synchronous level from the same clock.
 */
`timescale 1ns/10ps
module asc_rate_gen (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic [1:0] pre_sel,
    input  wire logic [2:0] tx_sel,
    input  wire logic [2:0] rx_sel,
    output logic            tx_tick,
    output logic            rx_tick
);
    logic [3:0] pre_cnt_r;
    logic [6:0] tx_cnt_r;
    logic [6:0] rx_cnt_r;
    logic       pre_tick;

    function automatic logic [3:0] pre_last(input logic [1:0] s);
        unique case (s)
            2'h0: return asc_pkg::PRE_LAST0;
            2'h1: return asc_pkg::PRE_LAST1;
            2'h2: return asc_pkg::PRE_LAST2;
            2'h3: return asc_pkg::PRE_LAST3;
        endcase
    endfunction

    function automatic logic [6:0] div_last(input logic [2:0] s);
        return 7'((8'h01 << s) - 8'h01);
    endfunction

    assign pre_tick = run && (pre_cnt_r >= pre_last(pre_sel));

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            pre_cnt_r <= 4'h0;
        else if (!run || pre_tick)
            pre_cnt_r <= 4'h0;
        else
            pre_cnt_r <= pre_cnt_r + 4'h1;
    end

    // >= keeps a shortened divisor from running past its end
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_cnt_r <= 7'h00;
            tx_tick  <= 1'b0;
        end
        else
        begin
            tx_tick <= pre_tick && (tx_cnt_r >= div_last(tx_sel));
            if (!run)
                tx_cnt_r <= 7'h00;
            else if (pre_tick)
                tx_cnt_r <= (tx_cnt_r >= div_last(tx_sel)) ? 7'h00
                                                           : tx_cnt_r + 7'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_cnt_r <= 7'h00;
            rx_tick  <= 1'b0;
        end
        else
        begin
            rx_tick <= pre_tick && (rx_cnt_r >= div_last(rx_sel));
            if (!run)
                rx_cnt_r <= 7'h00;
            else if (pre_tick)
                rx_cnt_r <= (rx_cnt_r >= div_last(rx_sel)) ? 7'h00
                                                           : rx_cnt_r + 7'h01;
        end
    end
endmodule // asc_rate_gen

// *** rtl/asc_top.sv ***
/*
 * Asynchronous serial controller: control, data and baud registers,
 * transmitter with preamble and break, receiver with mute and parity.
 * Assumes an Avalon-MM master on sys_clk and a raw line on rx_pin.
 */
// Contract
// - nine-bit mode stores and sends ninth bit
// - low-power bit stops rates after current byte
// - word length: eight or nine data bits
// - wake method: idle line or address mark
// - parity inserted at top bit and checked
// - parity enable applies from next byte
// - parity sense even/odd from next byte
// - parity error interrupts when enabled
// - empty and done flags interrupt when enabled
// - overrun or full interrupts when enabled
// - quiet line interrupts when enabled
// - enable toggle mid-word sends preamble after
// - one bit time before first transmission
// - tx pin released only when both off; code also releases it in low-power stop and before te is first set
// - receiver enable starts start-bit hunting
// - mute bit cleared by hardware on wake
// - break request sends break words
// - data address writes tx, reads rx holding
// - prescaler factor 1, 3, 4 or 13
// - tx/rx divisors power of two to 128
// - empty flag set on transfer, cleared sequence
`timescale 1ns/10ps
module asc_top (
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    input  wire logic [asc_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic                      rx_pin,
    output logic                           tx_pin_out,
    output logic                           tx_pin_oe,
    output logic                           irq
);
    typedef enum logic [5:0] {
        TX_OFF  = 6'h01,
        TX_WAIT = 6'h02,
        TX_IDLE = 6'h04,
        TX_DATA = 6'h08,
        TX_PRE  = 6'h10,
        TX_BRK  = 6'h20
    } asc_tx_t;
    typedef enum logic [2:0] {
        RX_OFF  = 3'h1,
        RX_HUNT = 3'h2,
        RX_DATA = 3'h4
    } asc_rx_t;

    logic [6:0]  ctrl1_r;
    logic [7:0]  ctrl2_r;
    logic [7:0]  baud_r;
    logic        rx_ninth_r;
    logic [7:0]  tx_holding_r;
    logic [7:0]  rx_holding_r;
    logic        tx_empty_flag_r, tc_r, rx_full_flag_r, idle_r, ovr_r, fe_r, pe_r;
    logic        stat_seen_r;
    asc_tx_t     tx_st_r;
    asc_rx_t     rx_st_r;
    logic [3:0]  tx_sub_r, tx_bit_r, tx_len_r;
    logic [10:0] tx_sh_r;
    logic        te_prev_r, brk_prev_r, pend_pre_r, brk_pend_r, te_ever_r;
    logic        rx_s1_r, rx_s2_r;
    logic [3:0]  rx_sub_r, rx_bit_r, rx_len_r;
    logic [9:0]  rx_sh_r;
    logic        rx_nine_r, rx_par_r, rx_odd_r, rx_done_r;
    logic [7:0]  idle_cnt_r;
    logic        idle_armed_r;
    logic        tx_tick, rx_tick;

    logic        req, wr_go, rd_go, tx_clr, rx_clr;
    logic        te, re, nine, lp_stop, tx_bit_end, tx_last, tx_start;
    logic        tx_load, tx_done_evt, rx_sample, idle_evt, mute_wake;
    logic        rx_accept;
    logic [8:0]  rx_word;
    logic        rx_top;
    logic [7:0]  status_vec;
    logic [7:0]  rd_mux;

    function automatic logic hit(input logic [asc_pkg::ADDR_W-1:0] a,
                                 input logic [6:0] i);
        return a == {i, 2'b00};
    endfunction

    // parity bit over the data below the top position
    function automatic logic par_of(input logic [8:0] w, input logic n9,
                                    input logic odd);
        return n9 ? ((^w[7:0]) ^ odd) : ((^w[6:0]) ^ odd);
    endfunction

    assign te   = ctrl2_r[asc_pkg::C2_TE];
    assign re   = ctrl2_r[asc_pkg::C2_RE];
    assign nine = ctrl1_r[asc_pkg::C1_NINE];
    assign req  = avs_read | avs_write;
    assign wr_go = avs_write & ~avs_waitrequest;
    assign rd_go = avs_read & ~avs_waitrequest;
    assign tx_clr = wr_go & avs_byteenable[0] & stat_seen_r
                  & hit(avs_address, asc_pkg::IDX_DATA);
    assign rx_clr = rd_go & stat_seen_r & hit(avs_address, asc_pkg::IDX_DATA);
    assign status_vec = {tx_empty_flag_r, tc_r, rx_full_flag_r, idle_r, ovr_r, 1'b0,
                         fe_r, pe_r};

    always_comb
    begin
        rd_mux = 8'h00;
        if (hit(avs_address, asc_pkg::IDX_STATUS))
            rd_mux = status_vec;
        else if (hit(avs_address, asc_pkg::IDX_DATA))
            rd_mux = rx_holding_r;
        else if (hit(avs_address, asc_pkg::IDX_BAUD))
            rd_mux = baud_r;
        else if (hit(avs_address, asc_pkg::IDX_CTRL1))
            rd_mux = {rx_ninth_r, ctrl1_r};
        else if (hit(avs_address, asc_pkg::IDX_CTRL2))
            rd_mux = ctrl2_r;
    end

    // one wait cycle, then the access completes
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else
        begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read & avs_waitrequest)
                avs_readdata <= {24'h00_0000, rd_mux};
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            stat_seen_r <= 1'b0;
        else if ((wr_go | rd_go) & hit(avs_address, asc_pkg::IDX_DATA))
            stat_seen_r <= 1'b0;
        else if (rd_go & hit(avs_address, asc_pkg::IDX_STATUS))
            stat_seen_r <= 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl1_r <= asc_pkg::CTRL1_RST;
            ctrl2_r <= asc_pkg::CTRL2_RST;
            baud_r  <= asc_pkg::BAUD_RST;
        end
        else
        begin
            if (wr_go & avs_byteenable[0])
            begin
                if (hit(avs_address, asc_pkg::IDX_CTRL1))
                    ctrl1_r <= avs_writedata[6:0];
                if (hit(avs_address, asc_pkg::IDX_BAUD))
                    baud_r <= avs_writedata[7:0];
            end
            if (wr_go & avs_byteenable[0]
                & hit(avs_address, asc_pkg::IDX_CTRL2))
                ctrl2_r <= avs_writedata[7:0];
            else if (mute_wake)
                ctrl2_r[asc_pkg::C2_MUTE] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            tx_holding_r <= 8'h00;
        else if (wr_go & avs_byteenable[0]
                 & hit(avs_address, asc_pkg::IDX_DATA))
            tx_holding_r <= avs_writedata[7:0];
    end

    // prescalers halt only between bytes
    assign lp_stop = ctrl1_r[asc_pkg::C1_LPOFF]
                   & (tx_st_r == TX_OFF || tx_st_r == TX_IDLE)
                   & (rx_st_r != RX_DATA);

    asc_rate_gen u_rate (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (~lp_stop),
        .pre_sel (baud_r[asc_pkg::BR_PRE_LSB +: 2]),
        .tx_sel  (baud_r[asc_pkg::BR_TX_LSB +: 3]),
        .rx_sel  (baud_r[asc_pkg::BR_RX_LSB +: 3]),
        .tx_tick (tx_tick),
        .rx_tick (rx_tick)
    );

    assign tx_bit_end  = tx_tick & (tx_sub_r == asc_pkg::TICK_LAST);
    assign tx_last     = tx_bit_r == tx_len_r - 4'h1;
    assign tx_start    = (tx_st_r == TX_IDLE) & te;
    assign tx_load     = tx_start & ~pend_pre_r & ~brk_pend_r
                       & ~ctrl2_r[asc_pkg::C2_BRK] & ~tx_empty_flag_r;
    assign tx_done_evt = (tx_st_r == TX_DATA) & tx_bit_end & tx_last;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_st_r  <= TX_OFF;
            tx_sub_r <= 4'h0;
            tx_bit_r <= 4'h0;
            tx_len_r <= asc_pkg::FRAME8;
            tx_sh_r  <= 11'h7FF;
        end
        else
        begin
            if (tx_tick)
                tx_sub_r <= tx_sub_r + 4'h1;
            unique case (tx_st_r)
                TX_OFF:
                    if (te)
                    begin
                        tx_st_r  <= TX_WAIT;
                        tx_sub_r <= 4'h0;
                    end
                TX_WAIT:
                    if (tx_bit_end)
                        tx_st_r <= TX_IDLE;
                TX_IDLE:
                begin
                    tx_sub_r <= 4'h0;
                    tx_bit_r <= 4'h0;
                    tx_len_r <= nine ? asc_pkg::FRAME9
                                     : asc_pkg::FRAME8;
                    if (!te)
                        tx_st_r <= TX_OFF;
                    else if (pend_pre_r)
                        tx_st_r <= TX_PRE;
                    else if (brk_pend_r | ctrl2_r[asc_pkg::C2_BRK])
                        tx_st_r <= TX_BRK;
                    else if (!tx_empty_flag_r)
                    begin
                        tx_st_r <= TX_DATA;
                        // mode and parity latched per word
                        tx_sh_r <= nine
                            ? {1'b1, ctrl1_r[asc_pkg::C1_PAR]
                                ? par_of({1'b0, tx_holding_r}, 1'b1,
                                         ctrl1_r[asc_pkg::C1_ODD])
                                : ctrl1_r[asc_pkg::C1_TX9],
                               tx_holding_r, 1'b0}
                            : {2'b11, ctrl1_r[asc_pkg::C1_PAR]
                                ? par_of({1'b0, tx_holding_r}, 1'b0,
                                         ctrl1_r[asc_pkg::C1_ODD])
                                : tx_holding_r[7],
                               tx_holding_r[6:0], 1'b0};
                    end
                end
                TX_DATA, TX_PRE, TX_BRK:
                    if (tx_bit_end)
                    begin
                        tx_bit_r <= tx_bit_r + 4'h1;
                        tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
                        if (tx_last)
                            tx_st_r <= TX_IDLE;
                    end
                default:
                    tx_st_r <= TX_OFF;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            te_prev_r  <= 1'b0;
            brk_prev_r <= 1'b0;
            pend_pre_r <= 1'b0;
            brk_pend_r <= 1'b0;
            te_ever_r  <= 1'b0;
        end
        else
        begin
            te_prev_r  <= te;
            brk_prev_r <= ctrl2_r[asc_pkg::C2_BRK];
            te_ever_r  <= te_ever_r | te;
            // a rise while busy means a clear happened mid-word
            if (te & ~te_prev_r & (tx_st_r == TX_DATA || tx_st_r == TX_PRE
                                   || tx_st_r == TX_BRK))
                pend_pre_r <= 1'b1;
            else if (tx_st_r == TX_PRE)
                pend_pre_r <= 1'b0;
            if (brk_prev_r & ~ctrl2_r[asc_pkg::C2_BRK])
                brk_pend_r <= 1'b1;
            else if (tx_st_r == TX_BRK)
                brk_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_pin_out <= 1'b1;
            tx_pin_oe  <= 1'b0;
        end
        else
        begin
            tx_pin_out <= (tx_st_r == TX_DATA) ? tx_sh_r[0]
                        : (tx_st_r != TX_BRK);
            tx_pin_oe  <= (te_ever_r | te) & (te | re) & ~lp_stop;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end
        else
        begin
            rx_s1_r <= rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    assign rx_sample = rx_tick & (rx_sub_r == asc_pkg::TICK_MID);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_st_r   <= RX_OFF;
            rx_sub_r  <= 4'h0;
            rx_bit_r  <= 4'h0;
            rx_len_r  <= asc_pkg::FRAME8;
            rx_sh_r   <= 10'h000;
            rx_nine_r <= 1'b0;
            rx_par_r  <= 1'b0;
            rx_odd_r  <= 1'b0;
            rx_done_r <= 1'b0;
        end
        else
        begin
            rx_done_r <= 1'b0;
            if (!re)
                rx_st_r <= RX_OFF;
            else
                unique case (rx_st_r)
                    RX_OFF:
                        rx_st_r <= RX_HUNT;
                    RX_HUNT:
                        if (rx_tick & ~rx_s2_r)
                        begin
                            rx_st_r   <= RX_DATA;
                            rx_sub_r  <= 4'h0;
                            rx_bit_r  <= 4'h0;
                            rx_len_r  <= nine ? asc_pkg::FRAME9
                                              : asc_pkg::FRAME8;
                            rx_nine_r <= nine;
                            rx_par_r  <= ctrl1_r[asc_pkg::C1_PAR];
                            rx_odd_r  <= ctrl1_r[asc_pkg::C1_ODD];
                        end
                    RX_DATA:
                    begin
                        if (rx_tick)
                            rx_sub_r <= rx_sub_r + 4'h1;
                        if (rx_sample)
                        begin
                            rx_bit_r <= rx_bit_r + 4'h1;
                            if (rx_bit_r != 4'h0)
                                rx_sh_r <= {rx_s2_r, rx_sh_r[9:1]};
                            if (rx_bit_r == 4'h0 && rx_s2_r)
                                rx_st_r <= RX_HUNT;
                            else if (rx_bit_r == rx_len_r - 4'h1)
                            begin
                                rx_st_r   <= RX_HUNT;
                                rx_done_r <= 1'b1;
                            end
                        end
                    end
                    default:
                        rx_st_r <= RX_OFF;
                endcase
        end
    end

    assign rx_word = rx_nine_r ? rx_sh_r[8:0] : {1'b0, rx_sh_r[8:1]};
    assign rx_top  = rx_nine_r ? rx_word[8] : rx_word[7];

    // idle line: one quiet frame while hunting
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            idle_cnt_r <= 8'h00;
        else if (rx_st_r != RX_HUNT || !rx_s2_r)
            idle_cnt_r <= 8'h00;
        else if (rx_tick && idle_cnt_r != {rx_len_r, 4'h0})
            idle_cnt_r <= idle_cnt_r + 8'h01;
    end

    assign idle_evt  = rx_tick & (rx_st_r == RX_HUNT) & rx_s2_r
                     & (idle_cnt_r == {rx_len_r, 4'h0} - 8'h01);
    assign mute_wake = ctrl2_r[asc_pkg::C2_MUTE]
                     & (ctrl1_r[asc_pkg::C1_WAKE] ? (rx_done_r & rx_top)
                                                  : idle_evt);
    // the address word that wakes is itself received
    assign rx_accept = rx_done_r
                     & (~ctrl2_r[asc_pkg::C2_MUTE] | mute_wake);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_holding_r <= 8'h00;
            rx_ninth_r   <= 1'b0;
        end
        else if (rx_accept & ~rx_full_flag_r)
        begin
            rx_holding_r <= rx_word[7:0];
            if (rx_nine_r)
                rx_ninth_r <= rx_word[8];
        end
    end

    // hardware sets win over the software clear sequence
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_empty_flag_r       <= 1'b1;
            tc_r         <= 1'b1;
            rx_full_flag_r       <= 1'b0;
            idle_r       <= 1'b0;
            ovr_r        <= 1'b0;
            fe_r         <= 1'b0;
            pe_r         <= 1'b0;
            idle_armed_r <= 1'b0;
        end
        else
        begin
            tx_empty_flag_r <= tx_load | (tx_empty_flag_r & ~tx_clr);
            tc_r   <= tx_done_evt | (tc_r & ~tx_clr);
            rx_full_flag_r <= (rx_accept & ~rx_full_flag_r) | (rx_full_flag_r & ~rx_clr);
            ovr_r  <= (rx_accept & rx_full_flag_r) | (ovr_r & ~rx_clr);
            fe_r   <= (rx_accept & ~rx_full_flag_r & ~rx_sh_r[9]) | (fe_r & ~rx_clr);
            pe_r   <= (rx_accept & ~rx_full_flag_r & rx_par_r
                       & (par_of(rx_word, rx_nine_r, rx_odd_r) != rx_top))
                    | (pe_r & ~rx_clr);
            idle_r <= (idle_evt & idle_armed_r & ~ctrl2_r[asc_pkg::C2_MUTE])
                    | (idle_r & ~rx_clr);
            if (rx_accept & ~rx_full_flag_r)
                idle_armed_r <= 1'b1;
            else if (idle_evt)
                idle_armed_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            irq <= 1'b0;
        else
            irq <= (ctrl1_r[asc_pkg::C1_PIE] & pe_r)
                 | (ctrl2_r[asc_pkg::C2_TIE] & tx_empty_flag_r)
                 | (ctrl2_r[asc_pkg::C2_DONE_IRQ_EN] & tc_r)
                 | (ctrl2_r[asc_pkg::C2_RIE] & (ovr_r | rx_full_flag_r))
                 | (ctrl2_r[asc_pkg::C2_QUIET_IRQ_EN] & idle_r);
    end
endmodule // asc_top

// *** test/asc_top_properties.sv ***
/* bus handshake and line timing checker for asc_top
   sees only the top ports; bound at the foot */
`timescale 1ns/10ps
module asc_top_props (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        tx_pin_out,
    input wire logic        tx_pin_oe,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // any bit lasts at least eight clocks
    sequence s_hi8; tx_pin_out [*8]; endsequence
    sequence s_lo8; !tx_pin_out [*8]; endsequence
    property p_rd_ack; $rose(avs_read) |=> !avs_waitrequest; endproperty
    property p_wr_ack; $rose(avs_write) |=> !avs_waitrequest; endproperty
    property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_rd_hi;
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
    endproperty
    property p_start; $fell(tx_pin_out) && tx_pin_oe |-> s_lo8; endproperty
    property p_bit; $rose(tx_pin_out) && tx_pin_oe |-> s_hi8; endproperty
    property p_oe_wait; $rose(tx_pin_oe) |-> s_hi8; endproperty
    property p_rst; $rose(rstn) |-> !irq && !tx_pin_oe; endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("no read ack");
    a_wr_ack: assert property (p_wr_ack) else $error("no write ack");
    a_ack_one: assert property (p_ack_one) else $error("long ack");
    a_rd_hi: assert property (p_rd_hi) else $error("upper data set");
    a_start: assert property (p_start) else $error("short low bit");
    a_bit: assert property (p_bit) else $error("short high bit");
    a_oe_wait: assert property (p_oe_wait) else $error("no idle");
    a_rst: assert property (p_rst) else $error("bad reset out");
endmodule // asc_top_props
bind asc_top asc_top_props u_props (.sys_clk(sys_clk), .rstn(rstn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_pin_out(tx_pin_out),
    .tx_pin_oe(tx_pin_oe), .irq(irq));

// *** test/asc_peer.sv ***
/* remote serial peer: sends frames on rx_pin, samples the tx line
   assumes the bench gives the bit period in clocks */
`timescale 1ns/10ps
module asc_peer (
    input  wire logic sys_clk,
    input  wire logic tx_line,
    output logic      rx_pin
);
    initial rx_pin = 1'h1;
    // start, n bits lsb first, stop; left high after
    task automatic send(input logic [8:0] w, input int n, input int bp);
        for (int i = 0; i < n + 2; i++)
        begin
            @(posedge sys_clk);
            rx_pin <= (i == 0) ? 1'h0 : (i > n) ? 1'h1 : w[i-1];
            repeat (bp - 1) @(posedge sys_clk);
        end
    endtask
    // samples mid-bit; w[n] holds the stop bit
    task automatic recv(output logic [9:0] w, input int n, input int bp);
        w = 10'h0;
        while (tx_line !== 1'h0) @(posedge sys_clk);
        repeat (bp / 2) @(posedge sys_clk);
        for (int i = 0; i <= n; i++)
        begin
            repeat (bp) @(posedge sys_clk);
            w[i] = tx_line;
        end
    endtask
endmodule // asc_peer

// *** test/asc_top_tb.sv ***
/* self-checking bench for asc_top: registers, frames, rates, irq
   assumes asc_peer on the line and a pull-up on the tx pin */
`timescale 1ns/10ps
`define CK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module asc_top_tb;
    logic        sys_clk = 1'h0;
    logic        rstn = 1'h0;
    logic [8:0]  avs_address = 9'h0;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, rx_pin, tx_pin_out, tx_pin_oe, irq;
    wire         tx_line = tx_pin_oe ? tx_pin_out : 1'h1;
    int          miscompares = 0;
    int          checks = 0;
    int          bp = 16;
    logic [7:0]  q;
    logic [9:0]  w;
    // baud settings and their bit periods: 16 * factor * 2^divisor
    logic [7:0]  bauds [4] = '{8'h00, 8'h49, 8'h9B, 8'hD2};
    int          periods [4] = '{16, 96, 512, 832};
    always #20 sys_clk = ~sys_clk;
    asc_top dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_pin(rx_pin), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
        .irq(irq));
    asc_peer peer (.sys_clk(sys_clk), .tx_line(tx_line), .rx_pin(rx_pin));
    task automatic tally_and_finish();
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic bus(input logic [6:0] i, input logic wr,
        input logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= {i, 2'h0};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
        q = avs_readdata[7:0];
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task automatic tx(input logic [7:0] d, input int n, input logic [9:0] e);
        fork
            peer.recv(w, n, bp);
            begin
                bus(asc_pkg::IDX_STATUS, 1'h0, 8'h00);
                bus(asc_pkg::IDX_DATA, 1'h1, d);
            end
        join
        `CK(w, e)
        repeat (bp) @(posedge sys_clk);
    endtask
    task automatic rx(input logic [8:0] d);
        peer.send(d, 8, bp);
        repeat (8) @(posedge sys_clk);
        bus(asc_pkg::IDX_STATUS, 1'h0, 8'h00);
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'h1;
        bus(asc_pkg::IDX_CTRL2, 1'h0, 8'h00);
        `CK(q, asc_pkg::CTRL2_RST)
        bus(asc_pkg::IDX_STATUS, 1'h0, 8'h00);
        `CK(q, 8'hC0)
        bus(7'h60, 1'h1, 8'hFF);
        bus(7'h60, 1'h0, 8'h00);
        `CK(q, 8'h00)
        bus(asc_pkg::IDX_CTRL2, 1'h1, 8'h88);
        repeat (3) @(posedge sys_clk);
        `CK({irq, tx_pin_oe}, 2'h3)
        bus(asc_pkg::IDX_CTRL2, 1'h1, 8'h0C);
        repeat (3) @(posedge sys_clk);
        `CK(irq, 1'h0)
        foreach (bauds[k])
        begin
            bus(asc_pkg::IDX_BAUD, 1'h1, bauds[k]);
            bp = periods[k];
            tx(8'h1D, 8, 10'h11D);
        end
        bus(asc_pkg::IDX_BAUD, 1'h1, 8'h00);
        bp = 16;
        bus(asc_pkg::IDX_CTRL1, 1'h1, 8'h50);
        tx(8'h3C, 9, 10'h33C);
        bus(asc_pkg::IDX_CTRL1, 1'h1, 8'h04);
        tx(8'h07, 8, 10'h187);
        bus(asc_pkg::IDX_CTRL1, 1'h1, 8'h06);
        tx(8'h07, 8, 10'h107);
        bus(asc_pkg::IDX_CTRL1, 1'h1, 8'h14);
        tx(8'h01, 9, 10'h301);
        bus(asc_pkg::IDX_CTRL1, 1'h1, 8'h00);
        rx(9'h05A);
        `CK(q & 8'h20, 8'h20)
        bus(asc_pkg::IDX_CTRL2, 1'h1, 8'h2C);
        repeat (2) @(posedge sys_clk);
        `CK(irq, 1'h1)
        bus(asc_pkg::IDX_DATA, 1'h0, 8'h00);
        `CK(q, 8'h5A)
        bus(asc_pkg::IDX_CTRL1, 1'h1, 8'h05);
        rx(9'h007);
        `CK({irq, q & 8'h21}, 9'h121)
        bus(asc_pkg::IDX_DATA, 1'h0, 8'h00);
        repeat (3) @(posedge sys_clk);
        `CK(irq, 1'h0)
        tally_and_finish();
    end
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end
endmodule // asc_top_tb
